// ---- rxcfg_pkg.sv ----
// constants and types for the receive configuration block
package rxcfg_pkg;
	// register indices, byte address is four times the index
	localparam logic [5:0] IDX_ACCESS   = 6'h08;
	localparam logic [5:0] IDX_TEMPLATE = 6'h09;
	localparam logic [5:0] IDX_RXCFG0   = 6'h0a;
	localparam logic [5:0] IDX_RXCFG1   = 6'h0b;
	// access control fields
	localparam int ACC_TRIG_BIT = 7;
	localparam int ACC_DIR_BIT  = 6;
	localparam int ACC_IV_LSB   = 4;
	localparam int ACC_SMP_LSB  = 0;
	// receiver config 0 fields
	localparam int RC0_PWDN_BIT = 4;
	localparam int RC0_INV_BIT  = 3;
	localparam int RC0_EDGE_BIT = 2;
	localparam int RC0_DEC_LSB  = 0;
	// receiver config 1 fields
	localparam int RC1_EQ_BIT  = 6;
	localparam int RC1_LOS_LSB = 0;
	// values after reset
	localparam logic [4:0] LOS_RST  = 5'h15;
	localparam logic [6:0] TDAT_RST = 7'h00;
	// loss threshold saturation code, and gap in dB between clear and declare levels
	localparam logic [4:0] LOS_SAT_CODE = 5'h16;
	localparam logic [5:0] LOS_GAP_DB   = 6'h04;
	// zero substitution decoding
	localparam logic [2:0] B8ZS_TAIL = 3'h4;
	localparam int         SR_W      = 8;
	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		DEC_ZSUB  = 2'b00,
		DEC_AMI   = 2'b01,
		DEC_DUAL  = 2'b10,
		DEC_SLICE = 2'b11
	} rx_decode_t;

	typedef enum logic [1:0] {
		IND_IDLE = 2'b00,
		IND_READ = 2'b01,
		IND_LOAD = 2'b10
	} ind_state_t;
endpackage

// ---- template_ram.sv ----
// pulse template storage, flip-flops with one write and one read port
module template_ram
	import rxcfg_pkg::*;
#(
	parameter int DATA_W = 7,
	parameter int ADDR_W = 6,
	parameter int DEPTH  = 64
) (
	// clock and reset
	input  wire logic              i_clk_sys,
	input  wire logic              i_rst_n,
	input  wire logic              i_clk_en,
	// write port
	input  wire logic              i_wr_en,
	input  wire logic [ADDR_W-1:0] i_wr_addr,
	input  wire logic [DATA_W-1:0] i_wr_data,
	// read port
	input  wire logic [ADDR_W-1:0] i_rd_addr,
	output logic      [DATA_W-1:0] o_rd_data
);
	typedef struct packed {
		logic [DEPTH-1:0][DATA_W-1:0] mem;
		logic [DATA_W-1:0]            rd;
	} ram_t;

	ram_t st_reg;
	ram_t st_next;

	always_comb begin
		st_next = st_reg;
		st_next.rd = st_reg.mem[i_rd_addr];
		// store into the addressed entry
		if (i_wr_en) begin
			st_next.mem[i_wr_addr] = i_wr_data;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg <= '0;
		end else if (i_clk_en) begin
			st_reg <= st_next;
		end
	end

	assign o_rd_data = st_reg.rd;

	default clocking cb @(posedge i_clk_sys iff i_clk_en); endclocking
	default disable iff (!i_rst_n);

	AST_RAM_STORE: assert property (
		i_wr_en |=> st_reg.mem[$past(i_wr_addr)] == $past(i_wr_data))
		else $error("template store lost");
endmodule

// ---- rx_line_format.sv ----
// receive data formatting: decode, retime, polarity, slicer pass
module rx_line_format
	import rxcfg_pkg::*;
(
	// clock and reset
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst_n,
	input  wire logic       i_clk_en,
	// line side pins
	input  wire logic       i_rclk,
	input  wire logic       i_pos,
	input  wire logic       i_neg,
	// settings
	input  wire logic       i_line_t1,
	input  wire logic [1:0] i_decode,
	input  wire logic       i_invert,
	input  wire logic       i_fall_edge,
	input  wire logic       i_power_down,
	// data out
	output logic            o_data,
	output logic            o_pos,
	output logic            o_neg
);
	typedef struct packed {
		logic [2:0]      s1;
		logic [2:0]      s2;
		logic            rclk_d;
		logic [SR_W-1:0] sr;
		logic [2:0]      tail;
		logic            seen;
		logic            last_pos;
		logic            dp;
		logic            dn;
		logic            rd;
		logic            rp;
		logic            rn;
	} fmt_t;

	fmt_t st_reg;
	fmt_t st_next;
	logic rise;
	logic upd;
	logic viol;
	logic mark;

	always_comb begin
		st_next = st_reg;
		st_next.s1 = {i_rclk, i_pos, i_neg};
		st_next.s2 = st_reg.s1;
		st_next.rclk_d = st_reg.s2[2];
		rise = st_reg.s2[2] && !st_reg.rclk_d;
		upd = i_fall_edge ? (!st_reg.s2[2] && st_reg.rclk_d) : rise;
		mark = st_reg.s2[1] || st_reg.s2[0];
		viol = mark && st_reg.seen && (st_reg.s2[1] == st_reg.last_pos);
		if (i_power_down) begin
			st_next.rd = i_invert;
			st_next.rp = i_invert;
			st_next.rn = i_invert;
		end else if (i_decode == DEC_SLICE) begin
			st_next.rd = i_invert;
			st_next.rp = st_reg.s2[1] ^ i_invert;
			st_next.rn = st_reg.s2[0] ^ i_invert;
		end else begin
			if (rise) begin
				st_next.dp = st_reg.s2[1];
				st_next.dn = st_reg.s2[0];
				st_next.sr = {st_reg.sr[SR_W-2:0], mark && st_reg.tail == 3'h0};
				if (st_reg.tail != 3'h0) begin
					st_next.tail = st_reg.tail - 3'h1;
				end else if (viol && i_decode == DEC_ZSUB) begin
					st_next.sr[3:0] = 4'h0;
					if (i_line_t1) begin
						st_next.tail = B8ZS_TAIL;
					end
				end
				if (mark) begin
					st_next.last_pos = st_reg.s2[1];
					st_next.seen = 1'b1;
				end
			end
			if (upd) begin
				if (i_decode == DEC_DUAL) begin
					st_next.rd = i_invert;
					st_next.rp = st_reg.dp ^ i_invert;
					st_next.rn = st_reg.dn ^ i_invert;
				end else begin
					st_next.rd = st_reg.sr[SR_W-1] ^ i_invert;
					st_next.rp = i_invert;
					st_next.rn = i_invert;
				end
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg <= '0;
		end else if (i_clk_en) begin
			st_reg <= st_next;
		end
	end

	assign o_data = st_reg.rd;
	assign o_pos = st_reg.rp;
	assign o_neg = st_reg.rn;

	default clocking cb @(posedge i_clk_sys iff i_clk_en); endclocking
	default disable iff (!i_rst_n);

	AST_SLICER_PASS: assert property (
		(i_decode == DEC_SLICE && !i_power_down && $stable(i_invert))[*4]
		|-> o_pos == ($past(i_pos, 3) ^ i_invert))
		else $error("slicer data not passed");
	AST_HOLD_BETWEEN_EDGES: assert property (
		!upd && !i_power_down && i_decode != DEC_SLICE && $stable(i_invert)
		|=> $stable(o_data))
		else $error("data changed off edge");
	AST_DUAL_RAILS: assert property (
		upd && !i_power_down && i_decode == DEC_DUAL
		|=> o_pos == ($past(st_reg.dp) ^ $past(i_invert)) && o_data == $past(i_invert))
		else $error("dual rail output wrong");
	AST_SINGLE_IDLE_RAILS: assert property (
		upd && !i_power_down && i_decode[1] == 1'b0
		|=> o_pos == $past(i_invert) && o_neg == $past(i_invert))
		else $error("rails active in single rail");
	AST_ZSUB_CLEAR: assert property (
		rise && viol && st_reg.tail == 3'h0 && !i_power_down && i_decode == DEC_ZSUB
		|=> st_reg.sr[3:0] == 4'h0)
		else $error("substitution not removed");
	AST_POWER_DOWN_IDLE: assert property (
		i_power_down |=> o_data == $past(i_invert) && o_pos == $past(i_invert))
		else $error("outputs active while powered down");
endmodule

// ---- rx_config_regs.sv ----
// receive path configuration registers behind an axi4-lite slave
module rx_config_regs
	import rxcfg_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// clock, enable, reset
	input  wire logic              i_clk_sys,
	input  wire logic              i_clk_en,
	input  wire logic              i_arst_n,
	// axi4-lite write address
	input  wire logic [ADDR_W-1:0] i_s_axi_awaddr,
	input  wire logic              i_s_axi_awvalid,
	output logic                   o_s_axi_awready,
	// axi4-lite write data
	input  wire logic [31:0]       i_s_axi_wdata,
	input  wire logic [3:0]        i_s_axi_wstrb,
	input  wire logic              i_s_axi_wvalid,
	output logic                   o_s_axi_wready,
	// axi4-lite write response
	output logic [1:0]             o_s_axi_bresp,
	output logic                   o_s_axi_bvalid,
	input  wire logic              i_s_axi_bready,
	// axi4-lite read address
	input  wire logic [ADDR_W-1:0] i_s_axi_araddr,
	input  wire logic              i_s_axi_arvalid,
	output logic                   o_s_axi_arready,
	// axi4-lite read data
	output logic [31:0]            o_s_axi_rdata,
	output logic [1:0]             o_s_axi_rresp,
	output logic                   o_s_axi_rvalid,
	input  wire logic              i_s_axi_rready,
	// line side
	input  wire logic              i_line_t1,
	input  wire logic              i_rclk,
	input  wire logic              i_rx_pos,
	input  wire logic              i_rx_neg,
	// receive data out
	output logic                   o_rx_data,
	output logic                   o_rx_positive_rail_out,
	output logic                   o_rx_negative_rail_out,
	// receive path controls
	output logic                   o_rx_power_down,
	output logic                   o_equalizer_enable,
	output logic [4:0]             o_signal_loss_threshold,
	output logic [5:0]             o_los_clear_db,
	output logic [5:0]             o_los_declare_db
);
	typedef struct packed {
		logic             awready;
		logic             wready;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             arready;
		logic             rvalid;
		logic [1:0]       rresp;
		logic [31:0]      rdata;
		logic             aw_have;
		logic [5:0]       aw_idx;
		logic             w_have;
		logic [7:0]       wd;
		logic             wstrb0;
		logic             acc_dir;
		logic [1:0]       acc_iv;
		logic [3:0]       acc_smp;
		logic [6:0]       tdata;
		logic             pwdn;
		logic             inv;
		logic             edge_fall;
		logic [1:0]       dec;
		logic             eq;
		logic [4:0]       los;
		logic [5:0]       los_clear;
		logic [5:0]       los_declare;
		ind_state_t       ind;
		logic             ram_we;
	} regs_t;

	regs_t      st_reg;
	regs_t      st_next;
	logic [1:0] rst_sync_reg;
	logic       rst_n;
	logic [6:0] ram_rd;
	logic       do_wr;
	logic [5:0] rd_idx;
	logic [4:0] los_sat;

	// reset release through two flops
	always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	always_comb begin
		st_next = st_reg;
		st_next.ram_we = 1'b0;
		do_wr = 1'b0;
		rd_idx = i_s_axi_araddr[7:2];
		los_sat = 5'h0;
		// write address and data, either order
		if (st_reg.awready && i_s_axi_awvalid) begin
			st_next.aw_have = 1'b1;
			st_next.aw_idx = i_s_axi_awaddr[7:2];
		end
		if (st_reg.wready && i_s_axi_wvalid) begin
			st_next.w_have = 1'b1;
			st_next.wd = i_s_axi_wdata[7:0];
			st_next.wstrb0 = i_s_axi_wstrb[0];
		end
		if (st_reg.bvalid && i_s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end
		if (st_next.aw_have && st_next.w_have && !st_reg.bvalid) begin
			do_wr = 1'b1;
			st_next.aw_have = 1'b0;
			st_next.w_have = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = RESP_OKAY;
		end
		// indirect read sequence
		case (st_reg.ind)
			IND_IDLE: begin
				st_next.ind = IND_IDLE;
			end
			IND_READ: begin
				st_next.ind = IND_LOAD;
			end
			IND_LOAD: begin
				st_next.tdata = ram_rd;
				st_next.ind = IND_IDLE;
			end
			default: begin
				st_next.ind = IND_IDLE;
			end
		endcase
		// register writes, reserved bits dropped
		if (do_wr) begin
			case (st_next.aw_idx)
				IDX_ACCESS: begin
					if (st_next.wstrb0) begin
						st_next.acc_dir = st_next.wd[ACC_DIR_BIT];
						st_next.acc_iv = st_next.wd[ACC_IV_LSB +: 2];
						st_next.acc_smp = st_next.wd[ACC_SMP_LSB +: 4];
						if (st_next.wd[ACC_TRIG_BIT] && st_reg.ind == IND_IDLE) begin
							if (st_next.wd[ACC_DIR_BIT]) begin
								st_next.ind = IND_READ;
							end else begin
								st_next.ram_we = 1'b1;
							end
						end
					end
				end
				IDX_TEMPLATE: begin
					if (st_next.wstrb0) begin
						st_next.tdata = st_next.wd[6:0];
					end
				end
				IDX_RXCFG0: begin
					if (st_next.wstrb0) begin
						st_next.pwdn = st_next.wd[RC0_PWDN_BIT];
						st_next.inv = st_next.wd[RC0_INV_BIT];
						st_next.edge_fall = st_next.wd[RC0_EDGE_BIT];
						st_next.dec = st_next.wd[RC0_DEC_LSB +: 2];
					end
				end
				IDX_RXCFG1: begin
					if (st_next.wstrb0) begin
						st_next.eq = st_next.wd[RC1_EQ_BIT];
						st_next.los = st_next.wd[RC1_LOS_LSB +: 5];
					end
				end
				default: begin
					st_next.bresp = RESP_SLVERR;
				end
			endcase
		end
		// loss levels from the threshold code
		los_sat = (st_next.los >= LOS_SAT_CODE) ? LOS_SAT_CODE : st_next.los;
		st_next.los_clear = {los_sat, 1'b0};
		st_next.los_declare = {los_sat, 1'b0} + LOS_GAP_DB;
		st_next.awready = !st_next.aw_have && !st_next.bvalid;
		st_next.wready = !st_next.w_have && !st_next.bvalid;
		// read channel
		if (st_reg.rvalid && i_s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
		if (st_reg.arready && i_s_axi_arvalid) begin
			st_next.rvalid = 1'b1;
			st_next.rresp = RESP_OKAY;
			st_next.rdata = 32'h0;
			case (rd_idx)
				IDX_ACCESS: begin
					st_next.rdata[7:0] = {st_reg.ind != IND_IDLE, st_reg.acc_dir,
						st_reg.acc_iv, st_reg.acc_smp};
				end
				IDX_TEMPLATE: begin
					st_next.rdata[6:0] = st_reg.tdata;
				end
				IDX_RXCFG0: begin
					st_next.rdata[4:0] = {st_reg.pwdn, st_reg.inv, st_reg.edge_fall,
						st_reg.dec};
				end
				IDX_RXCFG1: begin
					st_next.rdata[6:0] = {st_reg.eq, 1'b0, st_reg.los};
				end
				default: begin
					st_next.rresp = RESP_SLVERR;
				end
			endcase
		end
		st_next.arready = !st_next.rvalid;
	end

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
			st_reg.los <= LOS_RST;
			st_reg.tdata <= TDAT_RST;
			st_reg.los_clear <= {LOS_RST, 1'b0};
			st_reg.los_declare <= {LOS_RST, 1'b0} + LOS_GAP_DB;
		end else if (i_clk_en) begin
			st_reg <= st_next;
		end
	end

	template_ram #(
		.DATA_W (7),
		.ADDR_W (6),
		.DEPTH  (64)
	) u_ram (
		.i_clk_sys (i_clk_sys),
		.i_rst_n   (rst_n),
		.i_clk_en  (i_clk_en),
		.i_wr_en   (st_reg.ram_we),
		.i_wr_addr ({st_reg.acc_iv, st_reg.acc_smp}),
		.i_wr_data (st_reg.tdata),
		.i_rd_addr ({st_reg.acc_iv, st_reg.acc_smp}),
		.o_rd_data (ram_rd)
	);

	rx_line_format u_fmt (
		.i_clk_sys    (i_clk_sys),
		.i_rst_n      (rst_n),
		.i_clk_en     (i_clk_en),
		.i_rclk       (i_rclk),
		.i_pos        (i_rx_pos),
		.i_neg        (i_rx_neg),
		.i_line_t1    (i_line_t1),
		.i_decode     (st_reg.dec),
		.i_invert     (st_reg.inv),
		.i_fall_edge  (st_reg.edge_fall),
		.i_power_down (st_reg.pwdn),
		.o_data       (o_rx_data),
		.o_pos        (o_rx_positive_rail_out),
		.o_neg        (o_rx_negative_rail_out)
	);

	assign o_s_axi_awready = st_reg.awready;
	assign o_s_axi_wready = st_reg.wready;
	assign o_s_axi_bresp = st_reg.bresp;
	assign o_s_axi_bvalid = st_reg.bvalid;
	assign o_s_axi_arready = st_reg.arready;
	assign o_s_axi_rdata = st_reg.rdata;
	assign o_s_axi_rresp = st_reg.rresp;
	assign o_s_axi_rvalid = st_reg.rvalid;
	assign o_rx_power_down = st_reg.pwdn;
	assign o_equalizer_enable = st_reg.eq;
	assign o_signal_loss_threshold = st_reg.los;
	assign o_los_clear_db = st_reg.los_clear;
	assign o_los_declare_db = st_reg.los_declare;

	default clocking cb @(posedge i_clk_sys iff i_clk_en); endclocking
	default disable iff (!rst_n);

	AST_TRIGGER_WRITES_RAM: assert property (
		do_wr && st_next.aw_idx == IDX_ACCESS && st_next.wstrb0 && st_reg.ind == IND_IDLE
		&& st_next.wd[ACC_TRIG_BIT] && !st_next.wd[ACC_DIR_BIT]
		|=> st_reg.ram_we && st_reg.ind == IND_IDLE)
		else $error("write trigger did not store");
	AST_TRIGGER_READS_RAM: assert property (
		do_wr && st_next.aw_idx == IDX_ACCESS && st_next.wstrb0 && st_reg.ind == IND_IDLE
		&& st_next.wd[ACC_TRIG_BIT] && st_next.wd[ACC_DIR_BIT]
		|=> st_reg.ind == IND_READ ##1 st_reg.ind == IND_LOAD ##1 st_reg.ind == IND_IDLE)
		else $error("read trigger sequence wrong");
	AST_READ_LOADS_DATA: assert property (
		st_reg.ind == IND_LOAD && !(do_wr && st_next.aw_idx == IDX_TEMPLATE)
		|=> st_reg.tdata == $past(ram_rd))
		else $error("read data not loaded");
	AST_ADDR_FIELDS: assert property (
		do_wr && st_next.aw_idx == IDX_ACCESS && st_next.wstrb0
		|=> {st_reg.acc_iv, st_reg.acc_smp} == $past(st_next.wd[5:0]))
		else $error("template address not taken");
	AST_POWER_BIT: assert property (
		do_wr && st_next.aw_idx == IDX_RXCFG0 && st_next.wstrb0
		|=> o_rx_power_down == $past(st_next.wd[RC0_PWDN_BIT]))
		else $error("power down bit not applied");
	AST_EQ_BIT: assert property (
		do_wr && st_next.aw_idx == IDX_RXCFG1 && st_next.wstrb0
		|=> o_equalizer_enable == $past(st_next.wd[RC1_EQ_BIT]))
		else $error("equalizer bit not applied");
	AST_LOS_LEVELS: assert property (
		o_los_declare_db == o_los_clear_db + 6'h04 && o_los_clear_db <= 6'h2c
		&& (o_signal_loss_threshold < 5'h16 -> o_los_clear_db == {o_signal_loss_threshold, 1'b0}))
		else $error("loss levels wrong");
	AST_RESERVED_ZERO: assert property (
		o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h0)
		else $error("reserved read bits set");
	AST_BVALID_HOLD: assert property (
		o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
		else $error("write response dropped");

	COV_WRITE: cover property (o_s_axi_bvalid && i_s_axi_bready);
	COV_READ: cover property (o_s_axi_rvalid && i_s_axi_rready);
	COV_IND_READ: cover property (st_reg.ind == IND_LOAD);
	COV_RAM_WRITE: cover property (st_reg.ram_we);
endmodule

// ---- test_rx_config_regs.sv ----
// self-checking bench for the receive configuration register block
module test_rx_config_regs
	import rxcfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_sys, arst_n, line_t1, rclk, pos, neg, clk_en;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, seed, rd;
	logic [3:0]  wstrb;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, rs;
	logic        rx_data, rx_p, rx_n, pwdn, eq;
	logic [4:0]  thr;
	logic [5:0]  clr_db, dec_db;
	int          n_fail, n_checks, ram[64], rc0, rc1, tmpl, inv, m, k, a;
	int          addrs[$];
	logic [1:0]  hist[$];

	rx_config_regs #(.ADDR_W(8)) DUT (
		.i_clk_sys(clk_sys), .i_clk_en(clk_en), .i_arst_n(arst_n),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
		.i_s_axi_wdata(wdata), .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
		.i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
		.o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .i_line_t1(line_t1),
		.i_rclk(rclk), .i_rx_pos(pos), .i_rx_neg(neg), .o_rx_data(rx_data),
		.o_rx_positive_rail_out(rx_p), .o_rx_negative_rail_out(rx_n),
		.o_rx_power_down(pwdn), .o_equalizer_enable(eq),
		.o_signal_loss_threshold(thr), .o_los_clear_db(clr_db), .o_los_declare_db(dec_db)
	);

	always #4 clk_sys = ~clk_sys;

	function automatic logic [31:0] rnd();
		seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
		return seed;
	endfunction

	function automatic logic [5:0] los_db(input int c);
		return (c >= int'(LOS_SAT_CODE)) ? 6'h2c : 6'(2 * c);
	endfunction

	task automatic finish_test();
		if (n_fail == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic give_up();
		n_fail++;
		finish_test();
	endtask

	task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t pins got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic axi_write(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] r);
		bit ah, wh, bh, done;
		done = 0;
		@(posedge clk_sys);
		awaddr <= {idx, 2'h0};
		wdata <= {24'h0, d};
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 50 && !done; i++) begin
			@(negedge clk_sys);
			ah = awvalid && awready;
			wh = wvalid && wready;
			bh = bvalid;
			r = bresp;
			@(posedge clk_sys);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
			if (bh) begin
				bready <= 1'b0;
				done = 1;
			end
		end
		if (!done) give_up();
	endtask

	task automatic axi_read(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
		bit ah, rh, done;
		done = 0;
		@(posedge clk_sys);
		araddr <= {idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 50 && !done; i++) begin
			@(negedge clk_sys);
			ah = arvalid && arready;
			rh = rvalid;
			d = rdata;
			r = rresp;
			@(posedge clk_sys);
			if (ah) arvalid <= 1'b0;
			if (rh) begin
				rready <= 1'b0;
				done = 1;
			end
		end
		if (!done) give_up();
	endtask

	task automatic wr_chk(input logic [5:0] idx, input logic [7:0] d, input int exp);
		axi_write(idx, d, rs);
		chk_bus(32'(rs), 32'(RESP_OKAY));
		axi_read(idx, rd, rs);
		chk_bus(rd, exp);
	endtask

	task automatic period(input logic p, input logic n);
		@(posedge clk_sys);
		pos <= p;
		neg <= n;
		rclk <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rclk <= 1'b1;
		repeat (3) @(posedge clk_sys);
	endtask

	initial begin
		{clk_sys, arst_n, line_t1, rclk, pos, neg, awvalid, wvalid, bready} = '0;
		{arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
		seed = 32'h42cfc803;
		clk_en = 1'b1;
		n_fail = 0;
		n_checks = 0;
		rc0 = 0;
		rc1 = int'(LOS_RST);
		tmpl = 0;
		foreach (ram[i]) ram[i] = 0;
		repeat (20) @(posedge clk_sys);
		arst_n <= 1'b1;
		repeat (6) @(posedge clk_sys);
		// values after reset
		chk_pin({3'h0, thr}, 8'(rc1));
		chk_pin({2'h0, clr_db}, {2'h0, los_db(rc1)});
		chk_pin({2'h0, dec_db}, {2'h0, los_db(rc1) + LOS_GAP_DB});
		axi_read(IDX_RXCFG0, rd, rs);
		chk_bus(rd, rc0);
		axi_read(IDX_RXCFG1, rd, rs);
		chk_bus(rd, rc1);
		axi_read(IDX_TEMPLATE, rd, rs);
		chk_bus(rd, tmpl);
		// unmapped place
		axi_write(6'h3f, 8'hff, rs);
		chk_bus(32'(rs), 32'(RESP_SLVERR));
		axi_read(6'h3f, rd, rs);
		chk_bus({rd[29:0], rs}, {30'h0, RESP_SLVERR});
		// every threshold code, equalizer random
		for (int c = 0; c < 32; c++) begin
			rd = rnd();
			rc1 = int'({rd[7:5], 5'(c)}) & 'h5f;
			wr_chk(IDX_RXCFG1, {rd[7:5], 5'(c)}, rc1);
			chk_pin({7'h0, eq}, 8'(rc1 >> 6));
			chk_pin({3'h0, thr}, 8'(c));
			chk_pin({2'h0, clr_db}, {2'h0, los_db(c)});
			chk_pin({2'h0, dec_db}, {2'h0, los_db(c) + LOS_GAP_DB});
		end
		// indirect writes then reads, both corner addresses included
		for (int i = 0; i < 18; i++) begin
			a = (i == 0) ? 0 : (i == 1) ? 63 : int'(rnd() & 32'h3f);
			rd = rnd();
			tmpl = int'(rd[7:0]) & 'h7f;
			wr_chk(IDX_TEMPLATE, rd[7:0], tmpl);
			axi_write(IDX_ACCESS, 8'h80 | 8'(a), rs);
			ram[a] = tmpl;
			addrs.push_back(a);
		end
		foreach (addrs[i]) begin
			axi_write(IDX_ACCESS, 8'hc0 | 8'(addrs[i]), rs);
			rd = 32'h80;
			for (k = 0; k < 20 && rd[7] !== 1'b0; k++) axi_read(IDX_ACCESS, rd, rs);
			if (k == 20) give_up();
			axi_read(IDX_TEMPLATE, rd, rs);
			chk_bus(rd, ram[addrs[i]]);
		end
		// slicer mode, edge bit set on the inverted pass, then a frozen stretch
		for (inv = 0; inv < 2; inv++) begin
			rc0 = (inv << 3) | (inv << 2) | 3;
			wr_chk(IDX_RXCFG0, 8'(rc0) | 8'he0, rc0);
			hist.delete();
			for (int i = 0; i < 40; i++) begin
				@(posedge clk_sys);
				rd = rnd();
				pos <= rd[0];
				neg <= rd[1] & ~rd[0];
				rclk <= rd[2];
				hist.push_back({rd[0], rd[1] & ~rd[0]});
				@(negedge clk_sys);
				if (hist.size() > 3)
					chk_pin({6'h0, rx_p, rx_n}, {6'h0, hist[hist.size() - 4] ^ {2{inv[0]}}});
			end
			@(posedge clk_sys);
			clk_en <= 1'b0;
			for (int i = 0; i < 6; i++) begin
				@(posedge clk_sys);
				rd = rnd();
				pos <= rd[0];
				neg <= rd[1];
				@(negedge clk_sys);
				chk_pin({6'h0, rx_p, rx_n}, {6'h0, hist[hist.size() - 3] ^ {2{inv[0]}}});
			end
			@(posedge clk_sys);
			clk_en <= 1'b1;
		end
		// retimed dual rail, both edges and polarities
		for (m = 0; m < 4; m++) begin
			inv = m & 1;
			rc0 = (inv << 3) | ((m >> 1) << 2) | 2;
			wr_chk(IDX_RXCFG0, 8'(rc0), rc0);
			rd = rnd();
			repeat (4) period(rd[0], rd[1] & ~rd[0]);
			@(negedge clk_sys);
			chk_pin({5'h0, rx_data, rx_p, rx_n},
				{5'h0, 3'({1'b0, rd[0], rd[1] & ~rd[0]} ^ {3{inv[0]}})});
		end
		// single rail decoding, both line standards
		for (m = 0; m < 4; m++) begin
			rd = rnd();
			inv = int'(rd[0]);
			line_t1 <= m[1];
			rc0 = (inv << 3) | (int'(rd[1]) << 2) | (m & 1);
			wr_chk(IDX_RXCFG0, 8'(rc0), rc0);
			repeat (12) period(1'b0, 1'b0);
			@(negedge clk_sys);
			chk_pin({5'h0, rx_data, rx_p, rx_n}, {5'h0, {3{inv[0]}}});
			for (int i = 0; i < 12; i++) period(i[0], ~i[0]);
			@(negedge clk_sys);
			chk_pin({5'h0, rx_data, rx_p, rx_n}, {5'h0, 3'(3'h4 ^ {3{inv[0]}})});
		end
		// power down holds all outputs at the idle level
		for (inv = 0; inv < 2; inv++) begin
			rc0 = 'h10 | (inv << 3) | 3;
			wr_chk(IDX_RXCFG0, 8'(rc0), rc0);
			for (int i = 0; i < 10; i++) begin
				@(posedge clk_sys);
				rd = rnd();
				pos <= rd[0];
				neg <= rd[1];
			end
			@(negedge clk_sys);
			chk_pin({4'h0, pwdn, rx_data, rx_p, rx_n}, {5'h01, {3{inv[0]}}});
		end
		rc0 = 0;
		wr_chk(IDX_RXCFG0, 8'h00, rc0);
		chk_pin({7'h0, pwdn}, 8'h00);
		finish_test();
	end
endmodule
